// ### rbc_pkg.sv
// rbc_pkg: register map, field positions, reset values and timing for the bcd clock calendar
// assumes a single 10 MHz pclk domain shared by the clock device and its bus controller
package rbc_pkg;
    // device register offsets
    localparam logic [3:0] RBC_SEC1  = 4'h0;
    localparam logic [3:0] RBC_SEC10 = 4'h1;
    localparam logic [3:0] RBC_MIN1  = 4'h2;
    localparam logic [3:0] RBC_MIN10 = 4'h3;
    localparam logic [3:0] RBC_HR1   = 4'h4;
    localparam logic [3:0] RBC_HR10  = 4'h5;
    localparam logic [3:0] RBC_DAY1  = 4'h6;
    localparam logic [3:0] RBC_DAY10 = 4'h7;
    localparam logic [3:0] RBC_MON1  = 4'h8;
    localparam logic [3:0] RBC_MON10 = 4'h9;
    localparam logic [3:0] RBC_YR1   = 4'hA;
    localparam logic [3:0] RBC_YR10  = 4'hB;
    localparam logic [3:0] RBC_WEEK  = 4'hC;
    localparam logic [3:0] RBC_CTL_D = 4'hD;
    localparam logic [3:0] RBC_CTL_E = 4'hE;
    localparam logic [3:0] RBC_CTL_F = 4'hF;
    // implemented bits per register; all others store and read as zero
    localparam logic [15:0][3:0] RBC_IMPL_MASK = {
        4'hF, 4'hF, 4'hF, 4'h7, 4'hF, 4'hF, 4'h1, 4'hF,
        4'h3, 4'hF, 4'h7, 4'hF, 4'h7, 4'hF, 4'h7, 4'hF};
    // adjust_irq_hold_control fields
    localparam int RBC_D_HOLD = 0;
    localparam int RBC_D_BUSY = 1;
    localparam int RBC_D_IRQ  = 2;
    localparam int RBC_D_ADJ  = 3;
    // periodic_output_control fields
    localparam int RBC_E_GATE  = 0;
    localparam int RBC_E_PULSE = 1;
    localparam int RBC_E_RATE  = 2;
    // format_run_reset_control fields, and the pm bit of the hour tens register
    localparam int RBC_F_CLEAR = 0;
    localparam int RBC_F_STOP  = 1;
    localparam int RBC_F_24H   = 2;
    localparam int RBC_F_TEST  = 3;
    localparam int RBC_HR10_PM = 2;
    // rate field codes
    localparam logic [1:0] RBC_RATE_SUB  = 2'h0;
    localparam logic [1:0] RBC_RATE_SEC  = 2'h1;
    localparam logic [1:0] RBC_RATE_MIN  = 2'h2;
    localparam logic [1:0] RBC_RATE_HOUR = 2'h3;
    // time base and calendar reset values
    localparam int RBC_XTAL_HZ  = 32768;
    localparam int RBC_SUB_PER_SEC = 64;
    localparam int RBC_SUB_DIV  = RBC_XTAL_HZ / RBC_SUB_PER_SEC;
    localparam logic [3:0] RBC_RST_DAY1 = 4'h1;
    localparam logic [3:0] RBC_RST_MON1 = 4'h1;
    // system placement of the register block
    localparam logic [23:0] RBC_BASE_ADDR = 24'hDC0000;
    // host strobe timing
    localparam int RBC_CLK_NS  = 100;
    localparam int RBC_STRB_NS = 250;
    localparam int RBC_STRB_CYC = (RBC_STRB_NS + RBC_CLK_NS - 1) / RBC_CLK_NS;
    // controller apb map
    localparam logic [7:0] RBC_APB_CMD   = 8'h00;
    localparam logic [7:0] RBC_APB_STAT  = 8'h04;
    localparam logic [7:0] RBC_APB_ISTAT = 8'h08;
    localparam logic [7:0] RBC_APB_IMASK = 8'h0C;
    localparam int RBC_CMD_WRITE = 8;
    localparam int RBC_INT_DONE  = 0;
    localparam int RBC_INT_DEV   = 1;
endpackage

// ### rbc_bus_if.sv
// rbc_bus_if: 4-bit clock bus between the controller and the clock device
// assumes both ends run on the same pclk; data wire level resolved here from the enables
`timescale 1ns/10ps
interface rbc_bus_if;
    logic [3:0] addr;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       cs0_n;
    logic       cs1;
    logic [3:0] host_d_o;
    logic       host_d_oe;
    logic [3:0] dev_d_o;
    logic       dev_d_oe;
    logic [3:0] data;
    logic       periodic_irq_n;

    // undriven bus reads as zero
    assign data = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 4'h0);

    modport device (input addr, ale, rd_n, wr_n, cs0_n, cs1, data,
                    output dev_d_o, dev_d_oe, periodic_irq_n);
    modport host (output addr, ale, rd_n, wr_n, cs0_n, cs1, host_d_o, host_d_oe,
                  input data, periodic_irq_n);
endinterface

// ### rbc_device.sv
// rbc_device: bcd clock calendar with sixteen 4-bit registers on a strobed bus
// assumes bus inputs and xtal_tick are synchronous to pclk, one xtal_tick per crystal cycle
`timescale 1ns/10ps
module rbc_device
    import rbc_pkg::*;
#(
    parameter int XTAL_SUB_DIV = RBC_SUB_DIV
) (
    input wire logic  pclk,
    input wire logic  presetn,
    input wire logic  xtal_tick,
    rbc_bus_if.device bus
);
    function automatic logic [8:0] rbc_inc2(input logic [3:0] u, input logic [3:0] t,
                                             input logic [3:0] tlim);
        logic [8:0] r;
        r = {1'b0, t, u + 4'h1};
        if (u >= 4'h9) begin
            if (t >= tlim) begin
                r = {1'b1, 4'h0, 4'h0};
            end else begin
                r = {1'b0, t + 4'h1, 4'h0};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] rbc_month_days(input logic [7:0] mon, input logic leap);
        logic [7:0] d;
        d = 8'h31;
        if (mon == 8'h02) begin
            d = leap ? 8'h29 : 8'h28;
        end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
            d = 8'h30;
        end
        return d;
    endfunction

    logic [3:0]  tm [13];
    logic [3:0]  tn [13];
    logic [3:0]  addr_reg;
    logic        wr_n_reg;
    logic        hold_reg;
    logic        adj_reg;
    logic        irq_flag_reg;
    logic        pend_reg;
    logic [3:0]  pctl_reg;
    logic [3:0]  fctl_reg;
    logic [3:0]  rdata_reg;
    logic        irq_n_reg;
    logic [15:0] sub_cnt_reg;
    logic [5:0]  frac_reg;
    logic [3:0]  eff_addr;
    logic [3:0]  wdata;
    logic        sel;
    logic        wr_edge;
    logic        time_wr;
    logic        run;
    logic        sub_tick;
    logic        half_tick;
    logic        adj_go;
    logic        apply;
    logic        c_min;
    logic        c_hr;
    logic        c_day;
    logic        c_mon;
    logic        ev_periodic;
    logic        leap;
    logic [8:0]  inc_r;
    logic [7:0]  hv;

    localparam logic [15:0] SUB_LAST = 16'(XTAL_SUB_DIV - 1);
    localparam logic [15:0] SUB_HALF = 16'(XTAL_SUB_DIV / 2 - 1);

    // address is transparent while ale is high and held once it falls
    assign eff_addr = bus.ale ? bus.addr : addr_reg;
    assign sel      = !bus.cs0_n && bus.cs1;
    assign wdata    = bus.data & RBC_IMPL_MASK[eff_addr];
    assign wr_edge  = sel && !bus.wr_n && wr_n_reg;
    assign time_wr  = wr_edge && (eff_addr <= RBC_WEEK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= 4'h0;
            wr_n_reg <= 1'b1;
        end else begin
            wr_n_reg <= bus.wr_n;
            if (bus.ale) begin
                addr_reg <= bus.addr;
            end
        end
    end

    // time base: crystal ticks to 1/64 s, then 64 of those to one second
    assign run       = !fctl_reg[RBC_F_STOP] && !fctl_reg[RBC_F_CLEAR];
    assign sub_tick  = run && xtal_tick && (sub_cnt_reg == SUB_LAST);
    assign half_tick = run && xtal_tick && (sub_cnt_reg == SUB_HALF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_cnt_reg <= 16'h0000;
            frac_reg    <= 6'h00;
        end else if (fctl_reg[RBC_F_CLEAR]) begin
            sub_cnt_reg <= 16'h0000;
            frac_reg    <= 6'h00;
        end else if (run && xtal_tick) begin
            sub_cnt_reg <= sub_tick ? 16'h0000 : sub_cnt_reg + 16'h0001;
            if (sub_tick) begin
                frac_reg <= frac_reg + 6'h01;
            end
        end
    end

    // a second that falls inside hold or a host write waits in pend_reg; busy shows it
    assign adj_go = adj_reg && !hold_reg && !time_wr;
    assign apply  = pend_reg && !adj_go && !hold_reg && !time_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 1'b0;
        end else if (sub_tick && frac_reg == 6'h3F) begin
            pend_reg <= 1'b1;
        end else if (apply) begin
            pend_reg <= 1'b0;
        end
    end

    assign leap = tm[RBC_YR10][0] ? (tm[RBC_YR1] == 4'h2 || tm[RBC_YR1] == 4'h6) :
                  (tm[RBC_YR1] == 4'h0 || tm[RBC_YR1] == 4'h4 || tm[RBC_YR1] == 4'h8);
    assign hv   = {2'b00, tm[RBC_HR10][1:0], tm[RBC_HR1]};

    always_comb begin
        tn    = tm;
        c_min = 1'b0;
        c_hr  = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        inc_r = 9'h000;
        if (adj_go) begin
            tn[RBC_SEC1]  = 4'h0;
            tn[RBC_SEC10] = 4'h0;
            c_min         = tm[RBC_SEC10] >= 4'h3;
        end else if (apply) begin
            {c_min, tn[RBC_SEC10], tn[RBC_SEC1]} = rbc_inc2(tm[RBC_SEC1], tm[RBC_SEC10], 4'h5);
        end
        if (c_min) begin
            {c_hr, tn[RBC_MIN10], tn[RBC_MIN1]} = rbc_inc2(tm[RBC_MIN1], tm[RBC_MIN10], 4'h5);
        end
        if (c_hr) begin
            if (fctl_reg[RBC_F_24H]) begin
                if (hv >= 8'h23) begin
                    tn[RBC_HR10] = 4'h0;
                    tn[RBC_HR1]  = 4'h0;
                    c_day        = 1'b1;
                end else begin
                    inc_r        = rbc_inc2(tm[RBC_HR1], {2'b00, tm[RBC_HR10][1:0]}, 4'h2);
                    tn[RBC_HR10] = inc_r[7:4];
                    tn[RBC_HR1]  = inc_r[3:0];
                end
            end else if (hv >= 8'h11) begin
                tn[RBC_HR10] = {1'b0, !tm[RBC_HR10][RBC_HR10_PM], 2'b00};
                tn[RBC_HR1]  = 4'h0;
                c_day        = tm[RBC_HR10][RBC_HR10_PM];
            end else begin
                inc_r        = rbc_inc2(tm[RBC_HR1], {2'b00, tm[RBC_HR10][1:0]}, 4'h1);
                tn[RBC_HR10] = {1'b0, tm[RBC_HR10][RBC_HR10_PM], inc_r[5:4]};
                tn[RBC_HR1]  = inc_r[3:0];
            end
        end
        if (c_day) begin
            tn[RBC_WEEK] = (tm[RBC_WEEK] >= 4'h6) ? 4'h0 : tm[RBC_WEEK] + 4'h1;
            if ({tm[RBC_DAY10], tm[RBC_DAY1]} >=
                rbc_month_days({tm[RBC_MON10], tm[RBC_MON1]}, leap)) begin
                tn[RBC_DAY10] = 4'h0;
                tn[RBC_DAY1]  = 4'h1;
                c_mon         = 1'b1;
            end else begin
                inc_r         = rbc_inc2(tm[RBC_DAY1], tm[RBC_DAY10], 4'h3);
                tn[RBC_DAY10] = inc_r[7:4];
                tn[RBC_DAY1]  = inc_r[3:0];
            end
        end
        if (c_mon) begin
            if ({tm[RBC_MON10], tm[RBC_MON1]} >= 8'h12) begin
                tn[RBC_MON10] = 4'h0;
                tn[RBC_MON1]  = 4'h1;
                inc_r         = rbc_inc2(tm[RBC_YR1], tm[RBC_YR10], 4'h9);
                tn[RBC_YR10]  = inc_r[7:4];
                tn[RBC_YR1]   = inc_r[3:0];
            end else begin
                inc_r         = rbc_inc2(tm[RBC_MON1], tm[RBC_MON10], 4'h1);
                tn[RBC_MON10] = inc_r[7:4];
                tn[RBC_MON1]  = inc_r[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 13; i++) begin
                tm[i] <= 4'h0;
            end
            tm[RBC_DAY1] <= RBC_RST_DAY1;
            tm[RBC_MON1] <= RBC_RST_MON1;
        end else begin
            for (int i = 0; i < 13; i++) begin
                if (time_wr && eff_addr == 4'(i)) begin
                    tm[i] <= wdata;
                end else begin
                    tm[i] <= tn[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 1'b0;
            adj_reg  <= 1'b0;
            pctl_reg <= 4'h0;
            fctl_reg <= 4'h0;
        end else begin
            if (wr_edge && eff_addr == RBC_CTL_D) begin
                hold_reg <= wdata[RBC_D_HOLD];
                adj_reg  <= wdata[RBC_D_ADJ];
            end else if (adj_go) begin
                adj_reg <= 1'b0;
            end
            if (wr_edge && eff_addr == RBC_CTL_E) begin
                pctl_reg <= wdata;
            end
            if (wr_edge && eff_addr == RBC_CTL_F) begin
                fctl_reg <= wdata;
            end
        end
    end

    // periodic source chosen by the rate field
    always_comb begin
        unique case (pctl_reg[RBC_E_RATE +: 2])
            RBC_RATE_SUB:  ev_periodic = sub_tick;
            RBC_RATE_SEC:  ev_periodic = apply;
            RBC_RATE_MIN:  ev_periodic = c_min;
            RBC_RATE_HOUR: ev_periodic = c_hr;
        endcase
    end

    // new event wins over a clear in the same cycle; waveform mode self-clears at the middle of the next 1/64 s period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_reg <= 1'b0;
        end else if (ev_periodic) begin
            irq_flag_reg <= 1'b1;
        end else if (wr_edge && eff_addr == RBC_CTL_D && !bus.data[RBC_D_IRQ]) begin
            irq_flag_reg <= 1'b0;
        end else if (!pctl_reg[RBC_E_PULSE] && half_tick) begin
            irq_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n_reg <= 1'b1;
            rdata_reg <= 4'h0;
        end else begin
            irq_n_reg <= !(irq_flag_reg && !pctl_reg[RBC_E_GATE]);
            if (eff_addr <= RBC_WEEK) begin
                rdata_reg <= tm[eff_addr] & RBC_IMPL_MASK[eff_addr];
            end else if (eff_addr == RBC_CTL_D) begin
                rdata_reg <= {adj_reg, irq_flag_reg, pend_reg || adj_reg, hold_reg};
            end else if (eff_addr == RBC_CTL_E) begin
                rdata_reg <= pctl_reg;
            end else begin
                rdata_reg <= fctl_reg;
            end
        end
    end

    assign bus.dev_d_o        = rdata_reg;
    assign bus.dev_d_oe       = sel && !bus.rd_n;
    assign bus.periodic_irq_n = irq_n_reg;
endmodule // rbc_device

// ### rbc_host.sv
// rbc_host: apb-programmed controller that runs single accesses on the clock bus
// assumes software keeps to the hold/busy discipline and probes without writing
`timescale 1ns/10ps
module rbc_host
    import rbc_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    rbc_bus_if.host          bus
);
    typedef enum logic [1:0] {RBC_IDLE, RBC_ADDR, RBC_STRB, RBC_RECV} rbc_state_t;

    localparam logic [3:0] STRB_LAST = 4'(RBC_STRB_CYC - 1);

    rbc_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [3:0] addr_reg;
    logic [3:0] wdata_reg;
    logic       write_reg;
    logic [3:0] rdata_reg;
    logic [1:0] istat_reg;
    logic [1:0] imask_reg;
    logic       dev_irq_n_reg;
    logic       apb_wr;
    logic       start;
    logic       dev_ev;

    assign apb_wr = psel && penable && pwrite;
    assign start  = apb_wr && paddr == RBC_APB_CMD && state_reg == RBC_IDLE;
    assign dev_ev = !bus.periodic_irq_n && dev_irq_n_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RBC_IDLE;
            cnt_reg   <= 4'h0;
            addr_reg  <= 4'h0;
            wdata_reg <= 4'h0;
            write_reg <= 1'b0;
            rdata_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                RBC_IDLE: begin
                    if (start) begin
                        addr_reg  <= pwdata[3:0];
                        wdata_reg <= pwdata[7:4];
                        write_reg <= pwdata[RBC_CMD_WRITE];
                        state_reg <= RBC_ADDR;
                    end
                end
                RBC_ADDR: begin
                    cnt_reg   <= 4'h0;
                    state_reg <= RBC_STRB;
                end
                RBC_STRB: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == STRB_LAST) begin
                        if (!write_reg) begin
                            rdata_reg <= bus.data;
                        end
                        state_reg <= RBC_RECV;
                    end
                end
                RBC_RECV: begin
                    state_reg <= RBC_IDLE;
                end
            endcase
        end
    end

    // sticky events: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg     <= 2'b00;
            imask_reg     <= 2'b00;
            dev_irq_n_reg <= 1'b1;
        end else begin
            dev_irq_n_reg <= bus.periodic_irq_n;
            for (int i = 0; i < 2; i++) begin
                if ((i == RBC_INT_DONE && state_reg == RBC_RECV) ||
                    (i == RBC_INT_DEV && dev_ev)) begin
                    istat_reg[i] <= 1'b1;
                end else if (apb_wr && paddr == RBC_APB_ISTAT && pwdata[i]) begin
                    istat_reg[i] <= 1'b0;
                end
            end
            if (apb_wr && paddr == RBC_APB_IMASK) begin
                imask_reg <= pwdata[1:0];
            end
        end
    end

    always_comb begin
        unique case (paddr)
            RBC_APB_STAT:  prdata = {24'h000000, rdata_reg, 3'b000, state_reg != RBC_IDLE};
            RBC_APB_ISTAT: prdata = {30'h0, istat_reg};
            RBC_APB_IMASK: prdata = {30'h0, imask_reg};
            default:       prdata = 32'h00000000;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |(istat_reg & imask_reg);

    // one access: address cycle with ale, then the strobe, then a recovery cycle
    assign bus.addr      = addr_reg;
    assign bus.ale       = state_reg == RBC_ADDR;
    assign bus.cs0_n     = !(state_reg == RBC_ADDR || state_reg == RBC_STRB);
    assign bus.cs1       = state_reg == RBC_ADDR || state_reg == RBC_STRB;
    assign bus.rd_n      = !(state_reg == RBC_STRB && !write_reg);
    assign bus.wr_n      = !(state_reg == RBC_STRB && write_reg);
    assign bus.host_d_o  = wdata_reg;
    assign bus.host_d_oe = (state_reg == RBC_STRB) && write_reg;
endmodule // rbc_host

// ### rbc_bus_monitor.sv
// rbc_bus_monitor: concurrent checks on the clock bus between controller and device
// assumes one pclk domain; inputs are the bus interface signals
`timescale 1ns/10ps
module rbc_bus_monitor
    import rbc_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [3:0] addr,
    input wire logic       ale,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       cs0_n,
    input wire logic       cs1,
    input wire logic       host_d_oe,
    input wire logic [3:0] dev_d_o,
    input wire logic       dev_d_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_oe;
        dev_d_oe == (!cs0_n && cs1 && !rd_n);
    endproperty
    a_oe: assert property (p_oe) else $error("device data enable wrong");
    property p_excl;
        !(dev_d_oe && host_d_oe);
    endproperty
    a_excl: assert property (p_excl) else $error("both ends drive data");
    property p_rd;
        $fell(rd_n) |-> (!rd_n)[*3] ##1 rd_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe length wrong");
    property p_wr;
        $fell(wr_n) |-> (!wr_n && host_d_oe)[*3] ##1 wr_n;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe length wrong");
    property p_sel;
        (!rd_n || !wr_n) |-> (!cs0_n && cs1 && !ale);
    endproperty
    a_sel: assert property (p_sel) else $error("strobe without select");
    property p_ale;
        ($fell(rd_n) || $fell(wr_n)) |-> $past(ale) && $stable(addr);
    endproperty
    a_ale: assert property (p_ale) else $error("address not latched first");
    // unimplemented bits must never show up on a settled read
    property p_mask;
        (!rd_n && !$past(rd_n)) |-> (dev_d_o & ~RBC_IMPL_MASK[addr]) == 4'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("unimplemented bit read 1");
    property p_bcd;
        (!rd_n && !$past(rd_n)) |-> (addr != RBC_SEC1 || dev_d_o <= 4'h9)
            && (addr != RBC_SEC10 || dev_d_o <= 4'h5);
    endproperty
    a_bcd: assert property (p_bcd) else $error("seconds digit out of range");
endmodule // rbc_bus_monitor

// ### testbench.sv
// testbench: apb-driven controller joined to the clock device over the bus interface
// assumes a 10 MHz pclk and a crystal tick every 4 pclk cycles
`timescale 1ns/10ps
module testbench;
    import rbc_pkg::*;
    localparam int SUBDIV  = 2;
    localparam int SEC_CYC = 64 * SUBDIV * 4;
    // software probes the seconds digit at the block base and waits for it to tick
    localparam logic [23:0] PROBE_ADDR = RBC_BASE_ADDR | 24'(RBC_SEC1);
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        irq;
    logic        pslverr;
    logic        xtal_tick = 1'b0;
    logic [31:0] rd;
    int          tick_cnt = 0;
    int          miscompares = 0;
    int          checked = 0;
    int          n;
    // 11:59:58 pm, feb 28, year 24, weekday 6; and two seconds later
    logic [3:0]  tv [13] = '{4'h8, 4'h5, 4'h9, 4'h5, 4'h1, 4'h5, 4'h8, 4'h2, 4'h2, 4'h0,
                             4'h4, 4'h2, 4'h6};
    logic [3:0]  ev [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h9, 4'h2, 4'h2, 4'h0,
                             4'h4, 4'h2, 4'h0};
    rbc_bus_if bus ();
    rbc_device #(.XTAL_SUB_DIV(SUBDIV)) u_rbc_device (.pclk(pclk), .presetn(presetn),
        .xtal_tick(xtal_tick), .bus(bus.device));
    rbc_host u_rbc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .bus(bus.host));
    rbc_bus_monitor u_rbc_bus_monitor (.pclk(pclk), .presetn(presetn), .addr(bus.addr),
        .ale(bus.ale), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .cs0_n(bus.cs0_n), .cs1(bus.cs1),
        .host_d_oe(bus.host_d_oe), .dev_d_o(bus.dev_d_o), .dev_d_oe(bus.dev_d_oe));

    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        xtal_tick <= (tick_cnt == 3);
    end

    task automatic end_of_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data taken at the edge that samples pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        rd = prdata;
        chk({31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        // later looks at irq and status see values settled after the edge
        @(negedge pclk);
    endtask

    // one clock bus access through the controller, polled until not busy
    task automatic xfer(input logic wr, input logic [3:0] r, input logic [3:0] d);
        int k = 0;
        apb(1'b1, RBC_APB_CMD, {23'h0, wr, d, r});
        do begin
            apb(1'b0, RBC_APB_STAT, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 64);
        if (k >= 64) begin
            miscompares++;
            end_of_test();
        end
    endtask

    task automatic rdchk(input logic [3:0] r, input logic [3:0] e);
        xfer(1'b0, r, 4'h0);
        chk({28'h0, rd[7:4]}, {28'h0, e});
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        rdchk(RBC_DAY1, RBC_RST_DAY1);
        rdchk(RBC_MON1, RBC_RST_MON1);
        rdchk(PROBE_ADDR[3:0], 4'h0);
        repeat (SEC_CYC) @(posedge pclk);
        rdchk(PROBE_ADDR[3:0], 4'h1);
        apb(1'b1, RBC_APB_IMASK, 32'h3);
        xfer(1'b1, RBC_CTL_F, 4'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, RBC_APB_ISTAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        // unimplemented high bits of the tens digits drop the written 1
        for (int r = 0; r < 13; r++) begin
            xfer(1'b1, r[3:0], 4'h9);
            rdchk(r[3:0], 4'h9 & RBC_IMPL_MASK[r]);
        end
        for (int r = 0; r < 13; r++)
            xfer(1'b1, r[3:0], tv[r]);
        xfer(1'b1, RBC_CTL_F, 4'h0);
        repeat (2 * SEC_CYC + SEC_CYC / 4) @(posedge pclk);
        for (int r = 0; r < 13; r++)
            rdchk(r[3:0], ev[r]);
        xfer(1'b1, RBC_CTL_F, 4'h2);
        repeat (2 * SEC_CYC) @(posedge pclk);
        rdchk(RBC_SEC1, 4'h0);
        xfer(1'b1, RBC_SEC10, 4'h3);
        xfer(1'b1, RBC_CTL_D, 4'h8);
        rdchk(RBC_SEC10, 4'h0);
        rdchk(RBC_MIN1, 4'h1);
        rdchk(RBC_CTL_D, 4'h0);
        // 24-hour wrap through the adjust carry also rolls leap february into march
        xfer(1'b1, RBC_CTL_F, 4'h6);
        xfer(1'b1, RBC_HR10, 4'h2);
        xfer(1'b1, RBC_HR1, 4'h3);
        xfer(1'b1, RBC_MIN10, 4'h5);
        xfer(1'b1, RBC_MIN1, 4'h9);
        xfer(1'b1, RBC_SEC10, 4'h3);
        xfer(1'b1, RBC_CTL_D, 4'h8);
        rdchk(RBC_HR10, 4'h0);
        rdchk(RBC_HR1, 4'h0);
        rdchk(RBC_DAY1, 4'h1);
        rdchk(RBC_MON1, 4'h3);
        rdchk(RBC_WEEK, 4'h1);
        xfer(1'b1, RBC_CTL_E, 4'h6);
        xfer(1'b1, RBC_CTL_F, 4'h0);
        n = 0;
        while (bus.periodic_irq_n !== 1'b0 && n < 2 * SEC_CYC) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, bus.periodic_irq_n}, 32'h0);
        apb(1'b0, RBC_APB_ISTAT, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdchk(RBC_CTL_D, 4'h4);
        xfer(1'b1, RBC_CTL_D, 4'h4);
        rdchk(RBC_CTL_D, 4'h4);
        xfer(1'b1, RBC_CTL_D, 4'h0);
        rdchk(RBC_CTL_D, 4'h0);
        chk({31'h0, bus.periodic_irq_n}, 32'h1);
        // done is masked, so its sticky bit must not reach irq
        apb(1'b1, RBC_APB_IMASK, 32'h2);
        apb(1'b1, RBC_APB_ISTAT, 32'h3);
        xfer(1'b0, RBC_SEC1, 4'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, RBC_APB_ISTAT, 32'h0);
        chk(rd, 32'h1);
        // a second inside hold is deferred and shown as busy, then applied on release
        xfer(1'b1, RBC_CTL_D, 4'h1);
        repeat (SEC_CYC) @(posedge pclk);
        rdchk(RBC_CTL_D, 4'h3);
        xfer(1'b1, RBC_CTL_D, 4'h0);
        rdchk(RBC_CTL_D, 4'h4);
        end_of_test();
    end
endmodule // testbench
